// File: core/seb_defines.svh
`ifndef SEB_DEFINES_SVH
`define SEB_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SEB_CLK_NS       50
`define SEB_OUT_DLY_NS   300
`define SEB_PROG_BYTE_NS 1000000

// ----------------------------------------
// Address byte layout
// ----------------------------------------
// Device type code: value arbitrary
`define SEB_DEV_CODE 4'h6
`define SEB_F_CODE   7:4
`define SEB_F_CS     3:1
`define SEB_F_BLK    1
`define SEB_F_RW     0
`define SEB_MSB      7

// ----------------------------------------
// Byte framing and page sizes
// ----------------------------------------
// Bit count before the clock fall that follows START
`define SEB_BIT_START  4'hf
`define SEB_LAST_BIT   4'h7
`define SEB_ACK_SLOT   4'h8
`define SEB_PAGE_SMALL 4'h2
`define SEB_CNT_MAX    4'hf
`define SEB_UPPER_LG   8
`define SEB_UPPER_SM   7

`endif

// File: core/seb_pkg.sv
package seb_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WORD,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } seb_state_type;

endpackage

// File: core/seb_line_sync.sv
`timescale 1ns/1ps
`default_nettype none

module seb_line_sync #(
  parameter int         W    = 2,
  parameter logic [3:0] INIT = 4'h0
) (
  // Clock and reset
  input  wire  logic         ref_clk_i,
  input  wire  logic         nrst_i,
  // Lines
  input  wire  logic [W-1:0] line_i,
  output logic       [W-1:0] level_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_nxt;
  logic [W-1:0] level_r;

  // ----------------------------------------
  // Accept a change once stages two and three agree
  // ----------------------------------------
  always_comb begin
    level_nxt = level_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        level_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      s1_r    <= INIT[W-1:0];
      s2_r    <= INIT[W-1:0];
      s3_r    <= INIT[W-1:0];
      level_r <= INIT[W-1:0];
    end else begin
      s1_r    <= line_i;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level_o = level_r;

endmodule

`default_nettype wire

// File: core/seb_slave.sv
// Function
// - Data output changes at least 300 ns after clock falling edge.
// - Program cycle lasts one millisecond per buffered byte.
// - Data falling while clock high is START; commands begin with it.
// - Data rising while clock high is STOP; operations end with it.
// - Data changes only while clock low; one clock pulse per bit.
// - Addressed receiver acknowledges each byte on a ninth clock pulse.
// - No acknowledge at all while a program cycle runs.
// - Acknowledge holds data low through the whole ninth clock high phase.
// - Master not acknowledging ends a read; device releases data high.
// - Address byte holds type code and chip select; large variant block select.
// - Last address bit low means write, high means read.
// - Acknowledge address only on match and while not programming.
// - Byte after write address loads pointer low bits; block bit is ninth.
// - Acknowledge further write bytes and buffer them until STOP.
// - Page buffer holds two bytes small, eight bytes large.
// - Small variant: third data byte not acknowledged, write aborted.
// - Large variant: only low three pointer bits advance, page wraps.
// - STOP after first data byte gives single byte program.
// - STOP after buffered write starts program of all buffered bytes.
// - Write protected upper half: no acknowledge of first data byte.
// - Read sends addressed byte, advances pointer, continues while acknowledged.
// - Pointer wraps within its 256-byte block.
`include "seb_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module seb_slave #(
  parameter bit LARGE         = 1'b1,
  parameter int PROG_BYTE_CYC = `SEB_PROG_BYTE_NS / `SEB_CLK_NS
) (
  // Clock and reset
  input  wire  logic       ref_clk_i,
  input  wire  logic       nrst_i,
  // Two-wire bus
  input  wire  logic       scl_i,
  input  wire  logic       sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // Straps
  input  wire  logic       chip_select_bit0_or_block_select_i,
  input  wire  logic       chip_select_bit1_i,
  input  wire  logic       chip_select_bit2_i,
  input  wire  logic       write_protect_i,
  // Status
  output logic             busy_o
);

  localparam int         OUT_DLY_CYC = (`SEB_OUT_DLY_NS + `SEB_CLK_NS - 1) / `SEB_CLK_NS;
  localparam logic [3:0] PAGE        = LARGE ? {1'b0, 3'h7} + 4'h1 : `SEB_PAGE_SMALL;

  // ----------------------------------------
  // Input sampling
  // ----------------------------------------
  logic [1:0] bus_f;
  logic [3:0] strap_f;
  logic       scl_f;
  logic       sda_f;

  seb_line_sync #(.W(2), .INIT(4'h3)) u_bus_sync (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .line_i    ({scl_i, sda_i}),
    .level_o   (bus_f)
  );

  seb_line_sync #(.W(4), .INIT(4'h0)) u_strap_sync (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .line_i    ({write_protect_i, chip_select_bit2_i, chip_select_bit1_i,
                 chip_select_bit0_or_block_select_i}),
    .level_o   (strap_f)
  );

  assign scl_f = bus_f[1];
  assign sda_f = bus_f[0];

  // ----------------------------------------
  // State
  // ----------------------------------------
  seb_pkg::seb_state_type state_r, state_nxt;
  logic [3:0]  bit_r,   bit_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic [7:0]  tx_r,    tx_nxt;
  logic [8:0]  ptr_r,   ptr_nxt;
  logic        blk_r,   blk_nxt;
  logic        mack_r,  mack_nxt;
  logic [3:0]  cnt_r,   cnt_nxt;
  logic [7:0]  valid_r, valid_nxt;
  logic [7:0]  bufd_r [8];
  logic [7:0]  bufd_nxt [8];
  logic [8:0]  bufa_r [8];
  logic [8:0]  bufa_nxt [8];
  logic        busy_r,  busy_nxt;
  logic [2:0]  pidx_r,  pidx_nxt;
  logic [15:0] ptim_r,  ptim_nxt;
  logic        oe_r,    oe_nxt;
  logic        pend_r,  pend_nxt;
  logic [2:0]  dly_r,   dly_nxt;
  logic        scl_q,   sda_q;
  logic [7:0]  mem_r [512];
  logic        mem_we;

  logic scl_rise, scl_fall, start_ev, stop_ev, byte_end;
  logic [7:0] rd_byte;
  logic [7:0] b;
  logic       upper;

  assign scl_rise = scl_f & ~scl_q;
  assign scl_fall = ~scl_f & scl_q;
  assign start_ev = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_ev  = scl_f & scl_q & ~sda_q & sda_f;
  assign byte_end = scl_fall && bit_r == `SEB_LAST_BIT;
  assign rd_byte  = mem_r[ptr_r];
  assign b        = shift_r;
  assign upper    = LARGE ? ptr_r[`SEB_UPPER_LG] : ptr_r[`SEB_UPPER_SM];

  // Advance within the 256-byte block
  function automatic logic [8:0] blk_inc(input logic [8:0] p);
    blk_inc = {p[8], 8'(p[7:0] + 8'h01)};
  endfunction

  // Advance within the eight-byte page
  function automatic logic [8:0] page_inc(input logic [8:0] p);
    page_inc = {p[8:3], 3'(p[2:0] + 3'h1)};
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    bit_nxt   = bit_r;
    shift_nxt = shift_r;
    tx_nxt    = tx_r;
    ptr_nxt   = ptr_r;
    blk_nxt   = blk_r;
    mack_nxt  = mack_r;
    cnt_nxt   = cnt_r;
    valid_nxt = valid_r;
    bufd_nxt  = bufd_r;
    bufa_nxt  = bufa_r;
    busy_nxt  = busy_r;
    pidx_nxt  = pidx_r;
    ptim_nxt  = ptim_r;
    oe_nxt    = oe_r;
    pend_nxt  = pend_r;
    dly_nxt   = dly_r;
    mem_we    = 1'b0;

    // Delayed output update after a falling clock
    if (dly_r != 3'h0) begin
      dly_nxt = 3'(dly_r - 3'h1);
      if (dly_r == 3'h1) begin
        oe_nxt = pend_r;
      end
    end

    // Self-timed program engine
    if (busy_r) begin
      if (valid_r == 8'h00) begin
        busy_nxt = 1'b0;
      end else if (!valid_r[pidx_r]) begin
        pidx_nxt = 3'(pidx_r + 3'h1);
      end else if (ptim_r == 16'(PROG_BYTE_CYC - 1)) begin
        mem_we            = 1'b1;
        valid_nxt[pidx_r] = 1'b0;
        ptim_nxt          = 16'h0000;
        pidx_nxt          = 3'(pidx_r + 3'h1);
      end else begin
        ptim_nxt = 16'(ptim_r + 16'h0001);
      end
    end

    if (start_ev) begin
      state_nxt = seb_pkg::ST_ADDR;
      bit_nxt   = `SEB_BIT_START;
      oe_nxt    = 1'b0;
      dly_nxt   = 3'h0;
      if (!busy_r) begin
        valid_nxt = 8'h00;
        cnt_nxt   = 4'h0;
      end
    end else if (stop_ev) begin
      state_nxt = seb_pkg::ST_IDLE;
      oe_nxt    = 1'b0;
      dly_nxt   = 3'h0;
      if (state_r == seb_pkg::ST_WDATA && valid_r != 8'h00 && !busy_r) begin
        busy_nxt = 1'b1;
        pidx_nxt = 3'h0;
        ptim_nxt = 16'h0000;
      end
    end else if (scl_rise) begin
      if (bit_r == `SEB_ACK_SLOT) begin
        mack_nxt = ~sda_f;
      end else if (state_r != seb_pkg::ST_RDATA) begin
        shift_nxt = {shift_r[6:0], sda_f};
      end
    end else if (scl_fall && state_r != seb_pkg::ST_IDLE && state_r != seb_pkg::ST_IGNORE) begin
      dly_nxt  = 3'(OUT_DLY_CYC);
      pend_nxt = 1'b0;
      if (bit_r == `SEB_LAST_BIT) begin
        bit_nxt = `SEB_ACK_SLOT;
        case (state_r)
          seb_pkg::ST_ADDR: begin
            if (b[`SEB_F_CODE] == `SEB_DEV_CODE && !busy_r &&
                b[3:2] == strap_f[2:1] && (LARGE || b[`SEB_F_BLK] == strap_f[0])) begin
              pend_nxt  = 1'b1;
              blk_nxt   = LARGE ? b[`SEB_F_BLK] : 1'b0;
              state_nxt = b[`SEB_F_RW] ? seb_pkg::ST_RDATA : seb_pkg::ST_WORD;
              if (b[`SEB_F_RW]) begin
                ptr_nxt[8] = LARGE ? b[`SEB_F_BLK] : 1'b0;
              end
            end else begin
              state_nxt = seb_pkg::ST_IGNORE;
            end
          end
          seb_pkg::ST_WORD: begin
            ptr_nxt   = {blk_r, b};
            pend_nxt  = 1'b1;
            state_nxt = seb_pkg::ST_WDATA;
          end
          seb_pkg::ST_WDATA: begin
            if (!LARGE && cnt_r == PAGE) begin
              valid_nxt = 8'h00;
              state_nxt = seb_pkg::ST_IGNORE;
            end else if (strap_f[3] && upper) begin
              state_nxt = seb_pkg::ST_IGNORE;
            end else begin
              pend_nxt = 1'b1;
              if (LARGE) begin
                bufd_nxt[ptr_r[2:0]]  = b;
                bufa_nxt[ptr_r[2:0]]  = ptr_r;
                valid_nxt[ptr_r[2:0]] = 1'b1;
                ptr_nxt               = page_inc(ptr_r);
              end else begin
                bufd_nxt[cnt_r[2:0]]  = b;
                bufa_nxt[cnt_r[2:0]]  = ptr_r;
                valid_nxt[cnt_r[2:0]] = 1'b1;
                ptr_nxt               = blk_inc(ptr_r);
              end
              if (cnt_r != `SEB_CNT_MAX) begin
                cnt_nxt = 4'(cnt_r + 4'h1);
              end
            end
          end
          default: begin
          end
        endcase
      end else if (bit_r == `SEB_ACK_SLOT) begin
        bit_nxt = 4'h0;
        if (state_r == seb_pkg::ST_RDATA) begin
          if (mack_r) begin
            tx_nxt   = rd_byte;
            ptr_nxt  = blk_inc(ptr_r);
            pend_nxt = ~rd_byte[`SEB_MSB];
          end else begin
            state_nxt = seb_pkg::ST_IGNORE;
          end
        end
      end else begin
        bit_nxt = 4'(bit_r + 4'h1);
        if (state_r == seb_pkg::ST_RDATA) begin
          tx_nxt   = {tx_r[6:0], 1'b1};
          pend_nxt = ~tx_r[`SEB_MSB - 1];
        end
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state_r <= seb_pkg::ST_IDLE;
      bit_r   <= 4'h0;
      shift_r <= 8'h00;
      tx_r    <= 8'hff;
      ptr_r   <= 9'h000;
      blk_r   <= 1'b0;
      mack_r  <= 1'b0;
      cnt_r   <= 4'h0;
      valid_r <= 8'h00;
      bufd_r  <= '{default: 8'h00};
      bufa_r  <= '{default: 9'h000};
      busy_r  <= 1'b0;
      pidx_r  <= 3'h0;
      ptim_r  <= 16'h0000;
      oe_r    <= 1'b0;
      pend_r  <= 1'b0;
      dly_r   <= 3'h0;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end else begin
      state_r <= state_nxt;
      bit_r   <= bit_nxt;
      shift_r <= shift_nxt;
      tx_r    <= tx_nxt;
      ptr_r   <= ptr_nxt;
      blk_r   <= blk_nxt;
      mack_r  <= mack_nxt;
      cnt_r   <= cnt_nxt;
      valid_r <= valid_nxt;
      bufd_r  <= bufd_nxt;
      bufa_r  <= bufa_nxt;
      busy_r  <= busy_nxt;
      pidx_r  <= pidx_nxt;
      ptim_r  <= ptim_nxt;
      oe_r    <= oe_nxt;
      pend_r  <= pend_nxt;
      dly_r   <= dly_nxt;
      scl_q   <= scl_f;
      sda_q   <= sda_f;
    end
  end

  // Array storage, written only by the program engine
  always_ff @(posedge ref_clk_i) begin
    if (mem_we) begin
      mem_r[bufa_r[pidx_r]] <= bufd_r[pidx_r];
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_r;
  assign busy_o   = busy_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_byte_end;
    byte_end;
  endsequence

  sequence s_ack_high;
    bit_r == `SEB_ACK_SLOT && oe_r && scl_f;
  endsequence

  a_out_delay_hold: assert property (scl_fall |=> $stable(oe_r) [*5])
    else $error("output changed too soon after clock fall");
  a_ack_stays_low: assert property (s_ack_high |=> oe_r || scl_fall || $past(scl_fall))
    else $error("acknowledge released during clock high");
  a_busy_no_ack: assert property (busy_r && bit_r == `SEB_ACK_SLOT |-> !oe_r)
    else $error("acknowledge driven while programming");
  a_start_to_addr: assert property (start_ev |=> state_r == seb_pkg::ST_ADDR && bit_r == `SEB_BIT_START)
    else $error("start not followed by address phase");
  a_stop_to_idle: assert property (stop_ev |=> state_r == seb_pkg::ST_IDLE && !oe_r)
    else $error("stop did not return to idle");
  a_addr_mismatch: assert property (
    s_byte_end ##0 (state_r == seb_pkg::ST_ADDR && b[`SEB_F_CODE] != `SEB_DEV_CODE)
    |=> state_r == seb_pkg::ST_IGNORE)
    else $error("foreign address not ignored");
  a_prog_timing: assert property (mem_we |-> busy_r && ptim_r == 16'(PROG_BYTE_CYC - 1))
    else $error("array write off the program timer");
  a_prog_start: assert property ($rose(busy_r) |-> $past(stop_ev) && valid_r != 8'h00)
    else $error("program cycle started without buffered data");
  a_page_fixed: assert property (
    s_byte_end ##0 (LARGE && state_r == seb_pkg::ST_WDATA && !strap_f[3])
    |=> ptr_r[8:3] == $past(ptr_r[8:3]))
    else $error("page write moved upper pointer bits");
  a_nack_release: assert property (state_r == seb_pkg::ST_IGNORE |-> ##[0:7] !oe_r)
    else $error("data line not released after no acknowledge");

endmodule

`default_nettype wire

// File: sim/seb_bus_master.sv
`timescale 1ns/1ps
`default_nettype none

module seb_bus_master #(
  parameter int Q = 20
) (
  // Clock
  input  wire  logic ref_clk_i,
  // Bus lines
  input  wire  logic sda_i,
  output logic       scl_o,
  output logic       sda_low_o
);
  // Bus idle at start: both lines high
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  task automatic start_cond();
    sda_low_o = 1'b0;
    wait_cyc(Q / 2);
    scl_o = 1'b1;
    wait_cyc(Q * 5);
    sda_low_o = 1'b1;
    wait_cyc(Q * 4);
    scl_o = 1'b0;
    wait_cyc(Q / 2);
  endtask

  // One clock pulse per bit, data moved only while clock low
  task automatic bit_xfer(input logic b, output logic r);
    logic r0;
    sda_low_o = ~b;
    wait_cyc(Q / 2);
    scl_o = 1'b1;
    wait_cyc(2);
    r0 = sda_i;
    wait_cyc(Q - 2);
    r = (r0 === sda_i) ? sda_i : 1'bx;
    scl_o = 1'b0;
    wait_cyc(Q / 2);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = (r === 1'b0);
  endtask

  task automatic recv_byte(input logic ack_it, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(~ack_it, r);
  endtask

  task automatic stop_cond();
    sda_low_o = 1'b1;
    wait_cyc(Q / 2);
    scl_o = 1'b1;
    wait_cyc(Q * 5);
    sda_low_o = 1'b0;
    wait_cyc(Q * 5);
  endtask
endmodule

`default_nettype wire

// File: sim/seb_slave_tb.sv
`include "seb_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module seb_slave_tb;
  localparam int P = 2000;

  logic       ref_clk;
  logic       nrst;
  logic       scl;
  logic       sda_low;
  logic       oe;
  logic       busy;
  logic       cs0;
  logic       cs1;
  logic       cs2;
  logic       wp;
  wire  logic sda_line = ~(oe | sda_low);
  int         errors;
  int         n_checks;
  int         busy_cnt;
  time        t_fall;

  seb_slave #(.LARGE(1'b1), .PROG_BYTE_CYC(P)) seb_slave_inst (
    .ref_clk_i(ref_clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda_line),
    .sda_o(), .sda_oe_o(oe), .chip_select_bit0_or_block_select_i(cs0),
    .chip_select_bit1_i(cs1), .chip_select_bit2_i(cs2),
    .write_protect_i(wp), .busy_o(busy));

  seb_bus_master #(.Q(20)) seb_bus_master_inst (
    .ref_clk_i(ref_clk), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));

  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;
  always @(negedge scl) t_fall = $time;
  always @(posedge ref_clk) if (busy === 1'b1) busy_cnt++;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  always @(oe) if (nrst === 1'b1 && scl === 1'b0) check(8'(($time - t_fall) >= 300), 8'h1);

  task automatic test_done();
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  function automatic logic [7:0] ab(input logic blk, input logic rw);
    return {`SEB_DEV_CODE, cs2, cs1, blk, rw};
  endfunction

  task automatic write_seq(input logic blk, input logic [7:0] wa, input logic [7:0] q[$],
                           input logic exp_ack);
    logic ack;
    seb_bus_master_inst.start_cond();
    seb_bus_master_inst.send_byte(ab(blk, 1'b0), ack);
    check(8'(ack), 8'h1);
    seb_bus_master_inst.send_byte(wa, ack);
    check(8'(ack), 8'h1);
    foreach (q[i]) begin
      seb_bus_master_inst.send_byte(q[i], ack);
      check(8'(ack), 8'(exp_ack));
    end
    busy_cnt = 0;
    seb_bus_master_inst.stop_cond();
  endtask

  task automatic read_seq(input logic blk, input logic [7:0] wa, input logic [7:0] q[$]);
    logic [7:0] d;
    logic       ack;
    seb_bus_master_inst.start_cond();
    seb_bus_master_inst.send_byte(ab(blk, 1'b0), ack);
    seb_bus_master_inst.send_byte(wa, ack);
    seb_bus_master_inst.start_cond();
    seb_bus_master_inst.send_byte(ab(blk, 1'b1), ack);
    check(8'(ack), 8'h1);
    foreach (q[i]) begin
      seb_bus_master_inst.recv_byte(i < q.size() - 1, d);
      check(d, q[i]);
    end
    check(8'(oe), 8'h0);
    seb_bus_master_inst.stop_cond();
  endtask

  task automatic wait_prog(input int n);
    for (int i = 0; i < n * P + 100 && busy !== 1'b0; i++) @(negedge ref_clk);
    check(8'(busy_cnt >= n * P && busy_cnt <= n * P + 16), 8'h1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_addr_refuse();
    logic ack;
    logic [7:0] bad[2];
    bad[0] = ab(1'b0, 1'b0) ^ 8'h10;
    bad[1] = ab(1'b0, 1'b0) ^ 8'h04;
    foreach (bad[i]) begin
      seb_bus_master_inst.start_cond();
      seb_bus_master_inst.send_byte(bad[i], ack);
      check(8'(ack), 8'h0);
      seb_bus_master_inst.stop_cond();
    end
  endtask

  task automatic t_byte_write();
    logic ack;
    logic [7:0] q[$];
    q.push_back(8'ha5);
    write_seq(1'b1, 8'h00, q, 1'b1);
    check(8'(busy), 8'h1);
    seb_bus_master_inst.start_cond();
    seb_bus_master_inst.send_byte(ab(1'b1, 1'b0), ack);
    check(8'(ack), 8'h0);
    seb_bus_master_inst.stop_cond();
    wait_prog(1);
  endtask

  task automatic t_page_wrap();
    logic [7:0] q[$];
    logic [7:0] e[$];
    for (int k = 0; k < 10; k++) q.push_back(8'h30 + 8'(k));
    write_seq(1'b1, 8'hfe, q, 1'b1);
    wait_prog(8);
    e.push_back(8'h38);
    e.push_back(8'h39);
    e.push_back(8'ha5);
    read_seq(1'b1, 8'hfe, e);
  endtask

  task automatic t_protect();
    logic [7:0] q[$];
    q.push_back(8'h77);
    @(negedge ref_clk);
    wp = 1'b1;
    write_seq(1'b1, 8'h10, q, 1'b0);
    check(8'(busy), 8'h0);
    @(negedge ref_clk);
    wp = 1'b0;
  endtask

  task automatic t_straps();
    logic       ack;
    logic [7:0] old;
    old = ab(1'b1, 1'b0);
    @(negedge ref_clk);
    cs0 = 1'b0;
    cs1 = ~cs1;
    cs2 = ~cs2;
    seb_bus_master_inst.start_cond();
    seb_bus_master_inst.send_byte(old, ack);
    check(8'(ack), 8'h0);
    seb_bus_master_inst.stop_cond();
    seb_bus_master_inst.start_cond();
    seb_bus_master_inst.send_byte(ab(1'b1, 1'b0), ack);
    check(8'(ack), 8'h1);
    seb_bus_master_inst.stop_cond();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    cs0 = 1'b1;
    cs1 = 1'b1;
    cs2 = 1'b0;
    wp = 1'b0;
    errors = 0;
    n_checks = 0;
    busy_cnt = 0;
    t_fall = 0;
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (10) @(negedge ref_clk);
    t_addr_refuse();
    t_byte_write();
    t_page_wrap();
    t_protect();
    t_straps();
    test_done();
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    test_done();
  end
endmodule

`default_nettype wire
